// ===== result_port_pkg.sv
// Shared constants and types of the converter result output port.
// Assumes a 250 MHz system clock; every user writes result_port_pkg::name.
package result_port_pkg;

  // ****************************************************************
  // Widths and frame length
  // ****************************************************************
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_PERIOD_PS = 4000;
  // Half period of the generated master bit clock.
  localparam int MASTER_HALF_NS = 8;
  localparam int MASTER_HALF_CYCLES = (MASTER_HALF_NS * 1000) / CLOCK_PERIOD_PS;
  // Fastest external bit clock accepted in slave mode.
  localparam int SLAVE_MAX_SCLK_MHZ = 40;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {m_idle, m_run} master_state_type;

endpackage : result_port_pkg

// ===== shift_if.sv
// Interface between the port controller and its serial shift register.
// Both ends run on the same system clock.
`timescale 1ns/1ps
interface shift_if;
  logic load;
  logic [15:0] load_data;
  logic shift;
  logic chain_bit;
  logic msb;
  logic [4:0] count;

  modport ctrl (output load, output load_data, output shift, output chain_bit,
                input msb, input count);
  modport shifter (input load, input load_data, input shift, input chain_bit,
                   output msb, output count);
endinterface : shift_if

// ===== pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Register both stages.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : pin_sync

// ===== result_shifter.sv
// Serial shift register that sends a result most significant bit first.
// Assumes the controller raises shift once per bit clock and load at result end.
`timescale 1ns/1ps
module result_shifter (
  input wire logic clock,
  input wire logic nrst,
  shift_if.shifter sif
);

  logic [15:0] data_q;
  logic [15:0] data_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;

  // Load restarts the frame; each shift moves one bit and pulls in the chain bit.
  always_comb begin
    data_d = data_q;
    cnt_d = cnt_q;
    if (sif.load) begin
      data_d = sif.load_data;
      cnt_d = 5'h00;
    end else if (sif.shift) begin
      // Shifting goes on past the frame so upstream chain bits pass through.
      data_d = {data_q[14:0], sif.chain_bit};
      if (cnt_q < result_port_pkg::FRAME_BITS) begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  // Register shift state.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_q <= result_port_pkg::RESULT_RESET;
      cnt_q <= 5'h00;
    end else begin
      data_q <= data_d;
      cnt_q <= cnt_d;
    end
  end

  assign sif.msb = data_q[15];
  assign sif.count = cnt_q;

endmodule : result_shifter

// ===== adc_result_output_port.sv
// Result output port of a 16-bit sampling converter: parallel and serial paths.
// Assumes the conversion engine raises conv_done for one clock with conv_result
// valid, and that all pins arrive asynchronously to clock.
`timescale 1ns/1ps

// Notes on behaviour
// - Interface select low presents results on the 16-bit parallel bus.
// - Byte order low puts low byte on D[7:0], high byte on D[15:8].
// - Byte order high swaps the two bytes.
// - Interface select high shifts the result out serially, MSB first.
// - A serial result is exactly 16 bit clocks, valid on both edges.
// - Clock source low makes the device generate bit clock and frame valid.
// - Master mode can invert both generated bit clock and frame valid.
// - Master mode uses read timing to send after or during the next conversion.
// - Master read-after keeps busy high until all 16 bits are out.
// - Clock source high shifts data on the host's external bit clock.
// - Slave ignores bit clock unless chip select low; drives only when selected.
// - External clock may be continuous or gated, resting high or low.
// - Slave read-after: after busy falls, host clocks 16 bits with selects low.
// - Slave read-after accepts bit clock up to 40 MHz; host keeps under it.
// - Slave read-after uses read timing input as daisy chain input.
// - Chain input is taken on the opposite edge to the output shift.
// - Slave read-during pulses overrun if under 16 bits read at conversion end.
// - Chip select or read enable high puts the data outputs in high impedance.
// - A started conversion runs to completion; busy shows it is in progress.
// - Coding select picks two's complement or straight binary output.
module adc_result_output_port #(
  parameter int HALF_CYCLES = result_port_pkg::MASTER_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic convert_start_n,
  input wire logic interface_select,
  input wire logic byte_order_select,
  input wire logic clock_source_select,
  input wire logic output_coding_select,
  input wire logic master_invert_select,
  input wire logic read_timing_or_chain_input,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sclk_in,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  output logic conv_start,
  output logic busy,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  output logic serial_data_output,
  output logic serial_data_oe,
  output logic sclk_out,
  output logic sclk_oe,
  output logic frame_valid,
  output logic frame_valid_oe,
  output logic read_overrun_pulse
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [9:0] pins_s;
  logic cnv_n_s, par_ser_s, swap_s, slave_s, ob_s, inv_s, rtc_s, cs_n_s, rd_n_s, sclk_s;

  pin_sync #(.W(10)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in({convert_start_n, interface_select, byte_order_select, clock_source_select,
               output_coding_select, master_invert_select, read_timing_or_chain_input,
               cs_n, rd_n, sclk_in}),
    .sync_out(pins_s)
  );

  assign {cnv_n_s, par_ser_s, swap_s, slave_s, ob_s,
          inv_s, rtc_s, cs_n_s, rd_n_s, sclk_s} = pins_s;

  // ****************************************************************
  // Conversion tracking and result holding
  // ****************************************************************
  logic cnv_n_prev_q, cnv_n_prev_d;
  logic conv_active_q, conv_active_d;
  logic conv_start_q, conv_start_d;
  logic [15:0] hold_q, hold_d;
  logic [15:0] coded_result;
  logic start_evt, done_evt, read_en;
  logic slave_serial, master_serial, master_go;
  logic done_dly_q, done_dly_d, after_busy_q, after_busy_d, ovr_q, ovr_d;
  logic [15:0] data_out_q, data_out_d, par_word;
  logic sclk_prev_q, sclk_prev_d, chain_q, chain_d, rose_q, rose_d;
  logic sclk_rise, sclk_fall, slave_shift, master_load, master_shift;
  result_port_pkg::master_state_type m_state_q, m_state_d;
  logic [7:0] half_q, half_d;
  logic mclk_q, mclk_d;

  // Shift register of the serial path, reached through its interface.
  shift_if sif ();
  result_shifter u_shift (
    .clock(clock),
    .nrst(nrst),
    .sif(sif)
  );

  // Either select high releases every data output; both low enable a read.
  assign read_en = !cs_n_s && !rd_n_s;
  // A start edge is taken only while idle, so a conversion is never restarted.
  assign start_evt = cnv_n_prev_q && !cnv_n_s && !busy;
  assign done_evt = conv_done && conv_active_q;
  // Coding select high keeps straight binary; low inverts the sign bit.
  assign coded_result = ob_s ? conv_result : {~conv_result[15], conv_result[14:0]};

  // Next state of conversion tracking and of the holding register.
  always_comb begin
    cnv_n_prev_d = cnv_n_s;
    conv_active_d = conv_active_q;
    conv_start_d = start_evt;
    hold_d = hold_q;
    done_dly_d = done_evt;
    if (start_evt) begin
      conv_active_d = 1'b1;
    end else if (done_evt) begin
      conv_active_d = 1'b0;
    end
    if (done_evt) begin
      hold_d = coded_result;
    end
  end

  // Register conversion state; the edge detector clears to the synchroniser's reset level.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnv_n_prev_q <= 1'b0;
      conv_active_q <= 1'b0;
      conv_start_q <= 1'b0;
      hold_q <= result_port_pkg::RESULT_RESET;
      done_dly_q <= 1'b0;
    end else begin
      cnv_n_prev_q <= cnv_n_prev_d;
      conv_active_q <= conv_active_d;
      conv_start_q <= conv_start_d;
      hold_q <= hold_d;
      done_dly_q <= done_dly_d;
    end
  end

  assign conv_start = conv_start_q;
  // Busy covers the conversion and, in master read-after mode, the frame too.
  assign busy = conv_active_q || after_busy_q;

  // ****************************************************************
  // Parallel path
  // ****************************************************************
  // Byte order select exchanges the two bytes for an 8-bit host.
  assign par_word = swap_s ? {hold_q[7:0], hold_q[15:8]} : hold_q;
  // The parallel word follows the holding register while that path is chosen.
  always_comb begin
    data_out_d = data_out_q;
    if (!par_ser_s) begin
      data_out_d = par_word;
    end
  end
  // Register the parallel word.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_out_q <= result_port_pkg::RESULT_RESET;
    end else begin
      data_out_q <= data_out_d;
    end
  end
  assign data_out = data_out_q;
  assign data_oe = (!par_ser_s && read_en) ? 16'hffff : 16'h0000;

  // ****************************************************************
  // Slave serial path
  // ****************************************************************
  assign slave_serial = par_ser_s && slave_s;
  assign master_serial = par_ser_s && !slave_s;
  // Bit clock edges seen through the synchroniser; 40 MHz leaves three clocks a half.
  assign sclk_rise = !sclk_prev_q && sclk_s;
  assign sclk_fall = sclk_prev_q && !sclk_s;
  // A fall shifts only after a rise, so a clock resting high loses no bit.
  assign slave_shift = slave_serial && !cs_n_s && sclk_fall && rose_q;
  // Next state of edge tracking, chain capture and the overrun flag.
  always_comb begin
    sclk_prev_d = sclk_s;
    chain_d = chain_q;
    rose_d = rose_q;
    ovr_d = done_evt && slave_serial && (sif.count != 5'h00) &&
            (sif.count < result_port_pkg::FRAME_BITS);
    if (sif.load) begin
      rose_d = 1'b0;
    end else if (slave_serial && !cs_n_s && sclk_rise) begin
      rose_d = 1'b1;
      chain_d = rtc_s;
    end else if (slave_shift) begin
      rose_d = 1'b0;
    end
  end
  // Register slave state.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      chain_q <= 1'b0;
      rose_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      chain_q <= chain_d;
      rose_q <= rose_d;
      ovr_q <= ovr_d;
    end
  end
  assign read_overrun_pulse = ovr_q;

  // ****************************************************************
  // Master serial path
  // ****************************************************************
  // Read timing high sends the previous result during the next conversion.
  assign master_go = master_serial && (rtc_s ? start_evt : done_dly_q);
  // Next state of the master frame: half-period counter and generated bit clock.
  always_comb begin
    m_state_d = m_state_q;
    half_d = half_q;
    mclk_d = mclk_q;
    after_busy_d = after_busy_q;
    master_load = 1'b0;
    master_shift = 1'b0;
    unique case (m_state_q)
      result_port_pkg::m_idle: begin
        mclk_d = 1'b0;
        half_d = 8'h00;
        if (master_go) begin
          master_load = 1'b1;
          m_state_d = result_port_pkg::m_run;
        end
      end
      result_port_pkg::m_run: begin
        if (half_q == 8'(HALF_CYCLES - 1)) begin
          half_d = 8'h00;
          mclk_d = !mclk_q;
          if (mclk_q) begin
            master_shift = 1'b1;
            if (sif.count == result_port_pkg::FRAME_BITS - 5'h01) begin
              m_state_d = result_port_pkg::m_idle;
              after_busy_d = 1'b0;
            end
          end
        end else begin
          half_d = half_q + 8'h01;
        end
      end
    endcase
    // A result landing in read-after mode holds busy until its frame is out.
    if (done_evt && master_serial && !rtc_s) begin
      after_busy_d = 1'b1;
    end
  end
  // Register master state.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      m_state_q <= result_port_pkg::m_idle;
      half_q <= 8'h00;
      mclk_q <= 1'b0;
      after_busy_q <= 1'b0;
    end else begin
      m_state_q <= m_state_d;
      half_q <= half_d;
      mclk_q <= mclk_d;
      after_busy_q <= after_busy_d;
    end
  end

  // Generated clock and frame valid, inverted together when asked.
  assign sclk_out = mclk_q ^ inv_s;
  assign sclk_oe = master_serial;
  assign frame_valid = (m_state_q == result_port_pkg::m_run) ^ inv_s;
  assign frame_valid_oe = master_serial;

  // The shifter reloads one clock after each result is latched; in master read-during mode it loads at the next conversion start.
  assign sif.load = master_load || (!master_serial && done_dly_q);
  assign sif.load_data = hold_q;
  assign sif.shift = slave_serial ? slave_shift : master_shift;
  assign sif.chain_bit = slave_serial ? chain_q : 1'b0;
  // Serial data comes straight from the shifter's top flip-flop.
  assign serial_data_output = sif.msb;
  assign serial_data_oe = par_ser_s && read_en;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Frame steps; the lengths assume the default half period of two clocks.
  sequence s_master_begin;
    m_state_q == result_port_pkg::m_idle && master_go;
  endsequence
  sequence s_master_end;
    m_state_q == result_port_pkg::m_idle && sif.count == result_port_pkg::FRAME_BITS;
  endsequence
  sequence s_after_begin;
    done_evt && master_serial && !rtc_s && m_state_q == result_port_pkg::m_idle;
  endsequence
  a_master_frame: assert property (@(posedge clock) disable iff (!nrst)
    s_master_begin |=> ##64 s_master_end)
    else $error("master frame did not send sixteen bits in time");
  a_busy_after: assert property (@(posedge clock) disable iff (!nrst)
    s_after_begin |=> busy ##64 busy ##1 !busy)
    else $error("busy did not span the read-after frame");
  a_hold_latch: assert property (@(posedge clock) disable iff (!nrst)
    done_evt |=> hold_q == $past(coded_result))
    else $error("holding register missed a result");
  a_start_pulse: assert property (@(posedge clock) disable iff (!nrst)
    start_evt |=> conv_start && busy ##1 !conv_start)
    else $error("conversion start was not a single pulse with busy");
  a_release_outputs: assert property (@(posedge clock) disable iff (!nrst)
    cs_n_s || rd_n_s |-> data_oe == 16'h0000 && !serial_data_oe)
    else $error("data outputs driven while deselected");
  a_slave_gate: assert property (@(posedge clock) disable iff (!nrst)
    slave_serial && cs_n_s |-> !sif.shift)
    else $error("slave shifted while chip select was high");
  a_overrun_pulse: assert property (@(posedge clock) disable iff (!nrst)
    ovr_d |=> read_overrun_pulse ##1 !read_overrun_pulse)
    else $error("overrun was not a single pulse");
endmodule : adc_result_output_port

// ===== serial_host_model.sv
// Host model that reads the serial result as a bus master with its own bit clock.
// Assumes the bench sets chip select and read enable before calling read_bits.
`timescale 1ns/1ps
module serial_host_model (
  output logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // ****************************************************************
  // Gated bit clock, resting low, period 160 ns
  // ****************************************************************
  logic last = 1'b0;
  initial sclk = 1'b0;
  // Clocks n bits and takes each one at its rising edge; a released line reads inverted.
  task automatic read_bits(input int n, output logic [31:0] v);
    v = 32'h0000_0000;
    #1.3;
    for (int k = 0; k < n; k++) begin
      #80 sclk = 1'b1;
      last = sdo_oe ? sdo : ~last;
      v = {v[30:0], last};
      #80 sclk = 1'b0;
    end
  endtask : read_bits
endmodule : serial_host_model

// ===== test_adc_result_output_port.sv
// Self-checking bench of the result output port: parallel, slave serial and master serial paths.
// Assumes the bench plays the conversion engine through conv_done and conv_result.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_adc_result_output_port;
  logic clock = 1'b0, nrst = 1'b0, convert_start_n = 1'b1, interface_select = 1'b0;
  logic byte_order_select = 1'b0, clock_source_select = 1'b1, output_coding_select = 1'b1;
  logic master_invert_select = 1'b0, read_timing_or_chain_input = 1'b0, cs_n = 1'b0;
  logic rd_n = 1'b0, sclk_in, conv_done = 1'b0, conv_start, busy, serial_data_output;
  logic serial_data_oe, sclk_out, sclk_oe, frame_valid, frame_valid_oe, read_overrun_pulse;
  logic [15:0] conv_result = 16'h0000, data_out, data_oe, w;
  logic [31:0] seed = 32'hbf85, v;
  logic [15:0] mbits = 16'h0000;
  logic [15:0] hist[$];
  logic mprev = 1'b0, ovr_seen = 1'b0;
  int err_total = 0, checks_done = 0;
  adc_result_output_port uut (.clock, .nrst, .convert_start_n, .interface_select,
    .byte_order_select, .clock_source_select, .output_coding_select, .master_invert_select,
    .read_timing_or_chain_input, .cs_n, .rd_n, .sclk_in, .conv_done, .conv_result,
    .conv_start, .busy, .data_out, .data_oe, .serial_data_output, .serial_data_oe,
    .sclk_out, .sclk_oe, .frame_valid, .frame_valid_oe, .read_overrun_pulse);
  serial_host_model host (.sclk(sclk_in), .sdo(serial_data_output), .sdo_oe(serial_data_oe));
  // Clock of 4 ns period.
  always #2 clock = ~clock;
  // ****************************************************************
  // Model and helpers
  // ****************************************************************
  // Next random word of the linear feedback register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Starts a conversion, hands one random result to the port and models its coded form.
  task automatic new_result();
    seed = lfsr(seed);
    @(negedge clock);
    convert_start_n = 1'b0;
    conv_result = seed[15:0];
    output_coding_select = seed[16];
    repeat (4) @(negedge clock);
    convert_start_n = 1'b1;
    repeat (4) @(negedge clock);
    conv_done = 1'b1;
    @(negedge clock);
    conv_done = 1'b0;
    w = seed[16] ? seed[15:0] : seed[15:0] ^ 16'h8000;
    hist.push_back(w);
    repeat (8) @(negedge clock);
  endtask : new_result
  // Collects master bits at each generated rising edge in a frame, and any overrun.
  always @(negedge clock) begin
    mprev <= sclk_out ^ master_invert_select;
    if ((sclk_out ^ master_invert_select) && !mprev && (frame_valid ^ master_invert_select))
      mbits <= {mbits[14:0], serial_data_output};
    if (read_overrun_pulse)
      ovr_seen <= 1'b1;
  end
  // Prints counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Watchdog against a hang.
  initial begin
    #80000;
    err_total++;
    finish_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    // Parallel reads with both byte orders and both codings.
    for (int i = 0; i < 8; i++) begin
      byte_order_select = i[0];
      new_result();
      `CHK(data_out, i[0] ? {w[7:0], w[15:8]} : w)
    end
    cs_n = 1'b1;
    repeat (6) @(negedge clock);
    `CHK(data_oe, 16'h0000)
    cs_n = 1'b0;
    rd_n = 1'b1;
    repeat (6) @(negedge clock);
    `CHK(data_oe, 16'h0000)
    rd_n = 1'b0;
    repeat (6) @(negedge clock);
    `CHK(data_oe, 16'hffff)
    // Slave serial read after conversion, with stray clocks while deselected.
    // The host clocks only after busy falls, at 160 ns a bit.
    interface_select = 1'b1;
    for (int i = 0; i < 4; i++) begin
      new_result();
      cs_n = 1'b1;
      host.read_bits(3, v);
      `CHK(serial_data_oe, 1'b0)
      cs_n = 1'b0;
      read_timing_or_chain_input = seed[20];
      host.read_bits(17, v);
      `CHK(v[16:0], {w, seed[20]})
      @(negedge clock);
    end
    `CHK(ovr_seen, 1'b0)
    // A read cut short by the next result raises overrun; the chain input stays put.
    new_result();
    host.read_bits(5, v);
    `CHK(v[4:0], w[15:11])
    new_result();
    `CHK(ovr_seen, 1'b1)
    // Master read after conversion: busy spans the whole frame.
    clock_source_select = 1'b0;
    read_timing_or_chain_input = 1'b0;
    new_result();
    `CHK(busy, 1'b1)
    repeat (80) @(negedge clock);
    `CHK(busy, 1'b0)
    `CHK(mbits, w)
    // Master read during conversion, both strobes inverted, sends the previous result.
    read_timing_or_chain_input = 1'b1;
    master_invert_select = 1'b1;
    repeat (4) @(negedge clock);
    new_result();
    repeat (80) @(negedge clock);
    `CHK(mbits, hist[hist.size() - 2])
    finish_test();
  end
endmodule : test_adc_result_output_port
